// ==== sfrp_consts.vh ====
// Constants for the flash reset and power-on sequencer
`ifndef SFRP_CONSTS_VH
`define SFRP_CONSTS_VH

`define SFRP_CLK_MHZ            50
// Times in their own units
`define SFRP_RESET_PULSE_MIN_US 1
`define SFRP_RECOV_DECODE_US    20
`define SFRP_RECOV_READ_US      20
`define SFRP_RECOV_PROG_US      20
`define SFRP_RECOV_SRW_US       20
`define SFRP_RECOV_ERASE_MS     12
`define SFRP_PWR_SEL_DELAY_US   20
// Cycle counts derived from the clock rate
`define SFRP_RESET_PULSE_CYC    (`SFRP_RESET_PULSE_MIN_US * `SFRP_CLK_MHZ)
`define SFRP_RECOV_DECODE_CYC   (`SFRP_RECOV_DECODE_US * `SFRP_CLK_MHZ)
`define SFRP_RECOV_READ_CYC     (`SFRP_RECOV_READ_US * `SFRP_CLK_MHZ)
`define SFRP_RECOV_PROG_CYC     (`SFRP_RECOV_PROG_US * `SFRP_CLK_MHZ)
`define SFRP_RECOV_SRW_CYC      (`SFRP_RECOV_SRW_US * `SFRP_CLK_MHZ)
`define SFRP_RECOV_ERASE_CYC    (`SFRP_RECOV_ERASE_MS * 1000 * `SFRP_CLK_MHZ)
`define SFRP_PWR_SEL_CYC        (`SFRP_PWR_SEL_DELAY_US * `SFRP_CLK_MHZ)
// Operation codes for the interrupted activity
`define SFRP_OP_IDLE            3'h0
`define SFRP_OP_DECODE          3'h1
`define SFRP_OP_READ            3'h2
`define SFRP_OP_PROG            3'h3
`define SFRP_OP_ERASE           3'h4
`define SFRP_OP_SRW             3'h5
// Power-on defaults of volatile bits
`define SFRP_LOCK_DEFAULT       1'h0

`endif

// ==== sfrp_counter.v ====
// Loadable down-counter with done flag
`timescale 1ns/10ps
`default_nettype none
module sfrp_counter #(
   parameter W = 20
) (
   input  wire         clk_in,
   input  wire         rst_n_in,
   input  wire         load_in,
   input  wire [W-1:0] value_in,
   output reg          done_out
);
   reg [W-1:0] cnt_r;
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_r    <= {W{1'b0}};
         done_out <= 1'b0;
      end else if (load_in) begin
         cnt_r    <= value_in;
         done_out <= 1'b0;
      end else if (cnt_r != {W{1'b0}}) begin
         cnt_r    <= cnt_r - {{(W-1){1'b0}}, 1'b1};
         done_out <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
      end else begin
         done_out <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ==== sfrp_seq.v ====
// Reset and power-on sequencer of a serial flash
// How it works
// - A reset pin low for at least the minimum pulse width counts as a full reset.
// - After a full reset the part is in standby with all volatile bits at power-on values.
// - A reset during program or erase aborts that operation at once.
// - While the reset pin is low the serial output is not driven.
// - At power-up the part is in standby, not deep power-down, with the latch clear.
// - Below the power-on threshold the logic is held in reset and commands are ignored.
`timescale 1ns/10ps
`default_nettype none
`include "sfrp_consts.vh"
module sfrp_seq #(
   parameter CW            = 20,
   parameter RESET_PULSE   = `SFRP_RESET_PULSE_CYC,
   parameter RECOV_SHORT   = `SFRP_RECOV_DECODE_CYC,
   parameter RECOV_SRW     = `SFRP_RECOV_SRW_CYC,
   parameter RECOV_ERASE   = `SFRP_RECOV_ERASE_CYC,
   parameter PWR_SEL_DELAY = `SFRP_PWR_SEL_CYC
) (
   input  wire       clk_in,
   input  wire       rst_n_in,
   input  wire       por_ok_in,
   input  wire       hw_reset_n_in,
   input  wire       cs_n_in,
   input  wire [2:0] op_in,
   input  wire       so_data_in,
   input  wire       so_drive_in,
   input  wire       wel_set_in,
   input  wire       wel_clr_in,
   input  wire       wip_set_in,
   input  wire       wip_clr_in,
   input  wire       lock_set_in,
   input  wire       lock_clr_in,
   output reg        ready_out,
   output reg        cs_n_gated_out,
   output reg        abort_out,
   output reg        standby_out,
   output reg        so_out,
   output reg        so_oe_out,
   output reg        write_enable_latch_out,
   output reg        write_in_progress_out,
   output reg        lock_out
);
   // ----------------------------------------------------------
   // States
   // ----------------------------------------------------------
   localparam ST_POR   = 2'h0;
   localparam ST_RUN   = 2'h1;
   localparam ST_RESET = 2'h2;
   localparam ST_RECOV = 2'h3;

   reg [1:0]    state_r;
   reg [1:0]    state_nxt;
   reg [2:0]    op_held_r;
   reg [CW-1:0] pulse_cnt_r;
   reg          full_reset_r;
   reg          load_r;
   reg [CW-1:0] load_val_r;
   wire         wait_done;
   // Count value at the last low sample of a qualified pulse
   wire [CW-1:0] pulse_last = RESET_PULSE[CW-1:0] - {{(CW-2){1'b0}}, 2'h2};

   // Supply below threshold acts like a held reset
   wire hold_rst = !por_ok_in;

   sfrp_counter #(
      .W (CW)
   ) u_wait (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .load_in  (load_r),
      .value_in (load_val_r),
      .done_out (wait_done)
   );

   // ----------------------------------------------------------
   // Next state
   // ----------------------------------------------------------
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_POR: begin
            // A pin still low at the end of the delay keeps the part
            // waiting instead of running for one cycle into reset
            if (!hold_rst && hw_reset_n_in && wait_done && !load_r)
               state_nxt = ST_RUN;
         end
         ST_RUN: begin
            if (!hw_reset_n_in)
               state_nxt = ST_RESET;
         end
         ST_RESET: begin
            if (hw_reset_n_in)
               state_nxt = full_reset_r ? ST_RECOV : ST_RUN;
         end
         ST_RECOV: begin
            if (!hw_reset_n_in)
               state_nxt = ST_RESET;
            else if (wait_done && !load_r)
               state_nxt = ST_RUN;
         end
         default: state_nxt = ST_POR;
      endcase
      // Low supply overrides every state
      if (hold_rst)
         state_nxt = ST_POR;
   end

   // ----------------------------------------------------------
   // State and wait counter load
   // ----------------------------------------------------------
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_r    <= ST_POR;
         load_r     <= 1'b1;
         load_val_r <= PWR_SEL_DELAY[CW-1:0];
      end else begin
         state_r <= state_nxt;
         load_r  <= 1'b0;
         // Low supply reloads every cycle, so the select delay
         // runs from the first cycle the supply is good again
         if (hold_rst) begin
            load_r     <= 1'b1;
            load_val_r <= PWR_SEL_DELAY[CW-1:0];
         end else if (state_r == ST_RESET && state_nxt == ST_RECOV) begin
            load_r <= 1'b1;
            case (op_held_r)
               `SFRP_OP_ERASE: load_val_r <= RECOV_ERASE[CW-1:0];
               `SFRP_OP_SRW:   load_val_r <= RECOV_SRW[CW-1:0];
               default:        load_val_r <= RECOV_SHORT[CW-1:0];
            endcase
         end
      end
   end

   // ----------------------------------------------------------
   // Reset pulse qualification
   // ----------------------------------------------------------
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         op_held_r    <= `SFRP_OP_IDLE;
         pulse_cnt_r  <= {CW{1'b0}};
         full_reset_r <= 1'b0;
      end else if (state_r != ST_RESET && state_nxt == ST_RESET) begin
         // Interrupted activity picks the recovery length; a reset
         // during recovery keeps the first one
         op_held_r    <= (state_r == ST_RECOV) ? op_held_r : op_in;
         pulse_cnt_r  <= {CW{1'b0}};
         full_reset_r <= 1'b0;
      end else if (state_r == ST_RESET && !hw_reset_n_in) begin
         // Entry edge is the first low sample, so the count stops two
         // short of the width; RESET_PULSE must be two or more
         if (pulse_cnt_r != pulse_last)
            pulse_cnt_r <= pulse_cnt_r + {{(CW-1){1'b0}}, 1'b1};
         else
            full_reset_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------
   // Shared decodes
   // ----------------------------------------------------------
   // Volatile bits clear on a full reset or low supply
   wire vol_clr = hold_rst || (state_r == ST_RESET && full_reset_r);
   wire run_nxt = (state_nxt == ST_RUN);

   // ----------------------------------------------------------
   // Pin-facing outputs
   // ----------------------------------------------------------
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ready_out      <= 1'b0;
         cs_n_gated_out <= 1'b1;
         abort_out      <= 1'b0;
         standby_out    <= 1'b1;
         so_out         <= 1'b0;
         so_oe_out      <= 1'b0;
      end else begin
         ready_out      <= run_nxt;
         // Selects only reach the core once recovery is over
         cs_n_gated_out <= run_nxt ? cs_n_in : 1'b1;
         // Abort stays up in every state but run, so the core drops a
         // program or erase before the pulse is qualified; the data
         // being written may be left corrupt
         abort_out      <= !run_nxt;
         standby_out    <= !run_nxt || cs_n_in;
         so_out         <= so_data_in;
         // Pin term lets go of the output on the very first low sample
         so_oe_out      <= run_nxt && hw_reset_n_in && so_drive_in;
      end
   end

   // ----------------------------------------------------------
   // Volatile bits
   // ----------------------------------------------------------
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         write_enable_latch_out <= 1'b0;
         write_in_progress_out  <= 1'b0;
         lock_out               <= `SFRP_LOCK_DEFAULT;
      end else if (vol_clr) begin
         write_enable_latch_out <= 1'b0;
         write_in_progress_out  <= 1'b0;
         lock_out               <= `SFRP_LOCK_DEFAULT;
      end else if (state_r == ST_RUN) begin
         // Set wins over a clear in the same cycle
         if (wel_set_in)
            write_enable_latch_out <= 1'b1;
         else if (wel_clr_in)
            write_enable_latch_out <= 1'b0;
         if (wip_set_in)
            write_in_progress_out <= 1'b1;
         else if (wip_clr_in)
            write_in_progress_out <= 1'b0;
         if (lock_set_in)
            lock_out <= 1'b1;
         else if (lock_clr_in)
            lock_out <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== sfrp_seq_asserts.sv ====
// Checker of the reset and power-on sequencer
`timescale 1ns/10ps
`default_nettype none
module sfrp_seq_asserts (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic por_ok_in,
   input wire logic hw_reset_n_in,
   input wire logic wel_set_in,
   input wire logic ready_out,
   input wire logic cs_n_gated_out,
   input wire logic abort_out,
   input wire logic standby_out,
   input wire logic so_oe_out,
   input wire logic write_enable_latch_out,
   input wire logic write_in_progress_out,
   input wire logic lock_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   chk_oe_off: assert property (!hw_reset_n_in |=> !so_oe_out)
      else $error("so driven in reset");
   chk_abort_now: assert property (!hw_reset_n_in |=> abort_out && !ready_out)
      else $error("no abort on reset");
   // Five low samples equal the bench's qualified pulse width; the bits
   // clear on the edge after and are seen one sample later
   chk_bits_clear: assert property (!hw_reset_n_in [*5] |-> ##2
      !write_enable_latch_out && !write_in_progress_out && !lock_out)
      else $error("volatile bits kept");
   chk_standby_idle: assert property (!ready_out |-> standby_out)
      else $error("not standby");
   chk_por_hold: assert property (!por_ok_in |=> !ready_out && !write_enable_latch_out)
      else $error("active below threshold");
   chk_cs_gate: assert property (!ready_out |-> cs_n_gated_out)
      else $error("select passed early");
   chk_ready_src: assert property ($rose(ready_out) |-> $past(hw_reset_n_in) && $past(por_ok_in))
      else $error("ready during reset");
   chk_wel_set: assert property (ready_out && wel_set_in |=> write_enable_latch_out)
      else $error("latch not set");
endmodule
`default_nettype wire

// ==== sfrp_host.sv ====
// Host controller model driving chip select
`timescale 1ns/10ps
`default_nettype none
module sfrp_host (
   input  wire logic clk_in,
   input  wire logic rdy_in,
   input  wire logic req_in,
   input  wire logic early_in,
   output var logic  cs_n_out
);
   initial cs_n_out = 1'h1;
   // Early only when a test breaks the wait on purpose
   always @(posedge clk_in) cs_n_out <= #1 !(req_in && (rdy_in || early_in));
endmodule
`default_nettype wire

// ==== sfrp_tb.sv ====
// Testbench of the reset and power-on sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk_in, rst_n_in, por_ok_in, hw_reset_n_in, cs_n_in, so_data_in, so_drive_in;
   logic wel_set_in, wel_clr_in, wip_set_in, wip_clr_in, lock_set_in, lock_clr_in;
   logic [2:0] op_in;
   logic ready_out, cs_n_gated_out, abort_out, standby_out, so_out, so_oe_out;
   logic write_enable_latch_out, write_in_progress_out, lock_out, req, early;
   int n_fail = 0, samples_checked = 0, cyc = 0, w;
   sfrp_seq #(.RESET_PULSE(5), .RECOV_SHORT(10), .RECOV_SRW(10), .RECOV_ERASE(20),
      .PWR_SEL_DELAY(10)) uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .por_ok_in(por_ok_in), .hw_reset_n_in(hw_reset_n_in), .cs_n_in(cs_n_in),
      .op_in(op_in), .so_data_in(so_data_in), .so_drive_in(so_drive_in),
      .wel_set_in(wel_set_in), .wel_clr_in(wel_clr_in), .wip_set_in(wip_set_in),
      .wip_clr_in(wip_clr_in), .lock_set_in(lock_set_in), .lock_clr_in(lock_clr_in),
      .ready_out(ready_out), .cs_n_gated_out(cs_n_gated_out), .abort_out(abort_out),
      .standby_out(standby_out), .so_out(so_out), .so_oe_out(so_oe_out),
      .write_enable_latch_out(write_enable_latch_out),
      .write_in_progress_out(write_in_progress_out), .lock_out(lock_out));
   sfrp_host host (.clk_in(clk_in), .rdy_in(ready_out), .req_in(req), .early_in(early),
      .cs_n_out(cs_n_in));
   task automatic chk(string nm, logic e, logic s);
      samples_checked++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value %s exp %b got %b", nm, e, s);
      end
   endtask
   task automatic chk_n(string nm, int lo, int s);
      chk(nm, 1'h1, s >= lo && s < 200);
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic wait_rdy(output int c);
      c = 0;
      while (ready_out !== 1'h1 && c < 200) begin
         tick(1);
         c++;
      end
   endtask
   task automatic set_bits();
      {wel_set_in, wip_set_in, lock_set_in} = 3'h7;
      tick(1);
      {wel_set_in, wip_set_in, lock_set_in} = 3'h0;
      tick(1);
   endtask
   task automatic t_power();
      chk("standby", 1'h1, standby_out);
      chk("wel pwr", 1'h0, write_enable_latch_out);
      wait_rdy(w);
      chk_n("pwr wait", 9, w);
      req = 1'h1;
      tick(3);
      chk("cs pass", 1'h0, cs_n_gated_out);
      chk("oe run", 1'h1, so_oe_out);
      chk("so data", 1'h1, so_out);
      req = 1'h0;
      tick(2);
      $display("power-up test done");
   endtask
   task automatic t_short();
      set_bits();
      hw_reset_n_in = 1'h0;
      // One sample short of the qualified width
      tick(4);
      hw_reset_n_in = 1'h1;
      wait_rdy(w);
      chk("wel kept", 1'h1, write_enable_latch_out);
      chk("no recov", 1'h1, w < 5);
      $display("short pulse test done");
   endtask
   task automatic t_full(logic [2:0] op, int rec);
      op_in = op;
      set_bits();
      hw_reset_n_in = 1'h0;
      tick(2);
      chk("oe rst", 1'h0, so_oe_out);
      chk("abort", 1'h1, abort_out);
      {req, early} = 2'h3;
      // Five low samples in all: exactly the qualified width
      tick(3);
      chk("cs gate", 1'h1, cs_n_gated_out);
      hw_reset_n_in = 1'h1;
      wait_rdy(w);
      chk_n("recov", rec, w);
      chk("bits", 1'h0, write_enable_latch_out | write_in_progress_out | lock_out);
      {req, early, op_in} = 5'h00;
      tick(2);
      $display("full reset test done op %0d", op);
   endtask
   task automatic t_por();
      set_bits();
      por_ok_in = 1'h0;
      tick(2);
      chk("por rdy", 1'h0, ready_out);
      chk("por wel", 1'h0, write_enable_latch_out);
      por_ok_in = 1'h1;
      wait_rdy(w);
      chk_n("por wait", 9, w);
      $display("supply test done");
   endtask
   task automatic close_out();
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      clk_in = 1'h0;
      forever #10 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         close_out();
      end
   end
   initial begin
      {rst_n_in, por_ok_in, hw_reset_n_in, so_data_in, so_drive_in} = 5'h0F;
      {wel_set_in, wel_clr_in, wip_set_in, wip_clr_in, lock_set_in, lock_clr_in} = 6'h00;
      {op_in, req, early} = 5'h00;
      repeat (12) @(posedge clk_in);
      #1 rst_n_in = 1'h1;
      tick(1);
      t_power();
      t_short();
      for (int i = 1; i < 6; i++) t_full(i[2:0], (i == 4) ? 20 : 10);
      t_por();
      close_out();
   end
endmodule
bind sfrp_seq sfrp_seq_asserts chk_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .por_ok_in(por_ok_in), .hw_reset_n_in(hw_reset_n_in), .wel_set_in(wel_set_in),
   .ready_out(ready_out), .cs_n_gated_out(cs_n_gated_out), .abort_out(abort_out),
   .standby_out(standby_out), .so_oe_out(so_oe_out),
   .write_enable_latch_out(write_enable_latch_out),
   .write_in_progress_out(write_in_progress_out), .lock_out(lock_out));
`default_nettype wire
